// >>> verilog/stx_pkg.sv
package stx_pkg;

  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [7:0] STX_RX_CTRL_OFS  = 8'h00;
  localparam logic [7:0] STX_MODE_OFS     = 8'h04;
  localparam logic [7:0] STX_TX_CTRL_OFS  = 8'h08;
  localparam logic [7:0] STX_PAT1_OFS     = 8'h0C;
  localparam logic [7:0] STX_PAT2_OFS     = 8'h10;
  localparam logic [7:0] STX_MISC_OFS     = 8'h14;
  localparam logic [7:0] STX_CLK_MODE_OFS = 8'h18;
  localparam logic [7:0] STX_STATUS_OFS   = 8'h1C;
  localparam logic [7:0] STX_TX_BUF_OFS   = 8'h20;
  localparam logic [7:0] STX_RX_DATA_OFS  = 8'h24;
  localparam logic [7:0] STX_EXT_CTRL_OFS = 8'h28;

  // Field positions.
  localparam int STX_RX_EN_BIT     = 0;
  localparam int STX_RX_SEARCH_BIT = 4;
  localparam int STX_MODE_CHAR8    = 0;
  localparam int STX_MODE_PAT16    = 1;
  localparam int STX_MODE_EXT      = 2;
  localparam int STX_MODE_SDLC     = 3;
  localparam int STX_TX_CRC_BIT    = 0;
  localparam int STX_TX_EN_BIT     = 3;
  localparam int STX_TX_BREAK_BIT  = 4;
  localparam int STX_MISC_LOOP_BIT = 1;
  localparam int STX_MISC_POLL_BIT = 4;
  localparam int STX_CLK_XTAL_BIT  = 7;
  localparam int STX_ST_AVAIL_BIT  = 0;
  localparam int STX_ST_TXMT_BIT   = 2;
  localparam int STX_ST_SEARCH_BIT = 4;
  localparam int STX_ST_EVENT_BIT  = 6;
  localparam int STX_EXT_IE_BIT    = 0;

  // Values after reset and fixed figures.
  localparam logic [7:0]  STX_REG_RST    = 8'h00;
  localparam logic [15:0] STX_CRC_PRESET = 16'hFFFF;
  localparam logic [15:0] STX_CRC_POLY   = 16'h1021;
  localparam logic [4:0]  STX_LEN6       = 5'h06;
  localparam logic [4:0]  STX_LEN8       = 5'h08;
  localparam logic [4:0]  STX_LEN16      = 5'h10;
  localparam logic [1:0]  STX_RESP_OKAY  = 2'h0;
  localparam logic [1:0]  STX_RESP_SLV   = 2'h2;

  typedef enum logic [1:0] {
    STX_TX_IDLE = 2'h0,
    STX_TX_PAT  = 2'h1,
    STX_TX_DATA = 2'h3,
    STX_TX_CHK  = 2'h2
  } stx_tx_state_t;

endpackage : stx_pkg

// >>> verilog/stx_sync2.sv
module stx_sync2
  import stx_pkg::*;
#(
  parameter int W = 4
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  // Idle level of every line on this link is high.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= {W{1'b1}};
      q      <= {W{1'b1}};
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule : stx_sync2

// >>> verilog/stx_crc16.sv
module stx_crc16
  import stx_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        init,
  input  wire logic        step,
  input  wire logic        din,
  output logic      [15:0] crc
);

  logic fb;

  assign fb = din ^ crc[15];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      crc <= STX_CRC_PRESET;
    end else if (init) begin
      crc <= STX_CRC_PRESET;
    end else if (step) begin
      crc <= {crc[14:0], 1'b0} ^ (fb ? STX_CRC_POLY : 16'h0000);
    end
  end

endmodule : stx_crc16

// >>> verilog/stx_framer.sv
// Contract
// - Opening patterns skip check; data patterns counted
// - Check enable sampled at buffer-to-shifter move
// - Transparent mode sends buffer characters until disabled
// - External alignment keeps receiving after pin rises, outside SDLC
// - Transmitter starts one character after pattern found
// - Disabled transmitter idles ones, zeros with break
// - Disable mid-character finishes that character first
// - Disable during check sends pattern bits, idles
// - Search status shows alignment pin level in external alignment
// - Assembly starts next receive edge after activation
// - Both pin transitions raise event when enabled
// - Falling pin edge leaves search until command
// - SDLC: pin fall acts as received flag, pin rise re-enters search
module stx_framer
  import stx_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        tx_bit_clk,
  input  wire logic        rx_bit_clk,
  input  wire logic        rxd,
  input  wire logic        align_n,
  output logic             txd
);

  ////////////////////////////////////////////////////////////////////////////
  logic [3:0]    pin_s;
  logic [3:0]    pin_prev_r;
  logic          tx_tick, rx_tick, rxd_s, align_s, align_fall, align_rise;
  logic [7:0]    rx_ctl_r, mode_r, tx_ctl_r, pat1_r, pat2_r, misc_r, clk_mode_r;
  logic          align_ie_r;
  logic [7:0]    tx_buf_r;
  logic          tx_buf_full_r;
  logic          aw_got_r, w_got_r;
  logic [7:0]    aw_addr_r;
  logic [31:0]   w_data_r;
  logic          w_strb0_r;
  logic          wr_fire, wr_b0, rd_fire, wr_ok, rd_ok;
  logic [7:0]    rd_val;
  logic          ext_on, char8, loop_arm, tx_on, search_cmd;
  logic [4:0]    ch_len;

  // A single synchroniser bank for every pin that crosses into aclk.
  stx_sync2 #(.W(4)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({align_n, rxd, rx_bit_clk, tx_bit_clk}),
    .q       (pin_s)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_prev_r <= 4'hF;
    end else begin
      pin_prev_r <= pin_s;
    end
  end

  // Bits leave on the falling transmit edge and are sampled on the rising receive edge.
  assign tx_tick    = pin_prev_r[0] & ~pin_s[0];
  assign rx_tick    = ~pin_prev_r[1] & pin_s[1];
  assign rxd_s      = pin_s[2];
  assign align_s    = pin_s[3];
  assign align_fall = pin_prev_r[3] & ~pin_s[3];
  assign align_rise = ~pin_prev_r[3] & pin_s[3];

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: address and data may arrive in either order.
  assign s_axi_awready = ~aw_got_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_got_r & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_fire       = aw_got_r & w_got_r & ~s_axi_bvalid;
  assign wr_b0         = wr_fire & w_strb0_r;
  assign rd_fire       = s_axi_arvalid & s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb0_r <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r  <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_got_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r   <= 1'b1;
        w_data_r  <= s_axi_wdata;
        w_strb0_r <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_got_r <= 1'b0;
      end
    end
  end

  always_comb begin
    case (aw_addr_r)
      STX_RX_CTRL_OFS, STX_MODE_OFS, STX_TX_CTRL_OFS, STX_PAT1_OFS, STX_PAT2_OFS,
      STX_MISC_OFS, STX_CLK_MODE_OFS, STX_STATUS_OFS, STX_TX_BUF_OFS,
      STX_EXT_CTRL_OFS: wr_ok = 1'b1;
      default:          wr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= STX_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? STX_RESP_OKAY : STX_RESP_SLV;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_ctl_r   <= STX_REG_RST;
      mode_r     <= STX_REG_RST;
      tx_ctl_r   <= STX_REG_RST;
      pat1_r     <= STX_REG_RST;
      pat2_r     <= STX_REG_RST;
      misc_r     <= STX_REG_RST;
      clk_mode_r <= STX_REG_RST;
      align_ie_r <= 1'b0;
    end else if (wr_b0) begin
      case (aw_addr_r)
        STX_RX_CTRL_OFS:  rx_ctl_r <= w_data_r[7:0] & ~(8'h01 << STX_RX_SEARCH_BIT);
        STX_MODE_OFS:     mode_r <= w_data_r[7:0];
        STX_TX_CTRL_OFS:  tx_ctl_r <= w_data_r[7:0];
        STX_PAT1_OFS:     pat1_r <= w_data_r[7:0];
        STX_PAT2_OFS:     pat2_r <= w_data_r[7:0];
        STX_MISC_OFS:     misc_r <= w_data_r[7:0];
        STX_CLK_MODE_OFS: clk_mode_r <= w_data_r[7:0];
        STX_EXT_CTRL_OFS: align_ie_r <= w_data_r[STX_EXT_IE_BIT];
        default:          ;
      endcase
    end
  end

  // The search command is a one-shot and never reads back as set.
  assign search_cmd = wr_b0 & (aw_addr_r == STX_RX_CTRL_OFS) & w_data_r[STX_RX_SEARCH_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode. With the crystal on, the alignment pin is not free, so
  // external alignment is refused rather than following a dead pin.
  assign ext_on   = mode_r[STX_MODE_EXT] & ~clk_mode_r[STX_CLK_XTAL_BIT];
  assign char8    = mode_r[STX_MODE_CHAR8];
  assign ch_len   = char8 ? STX_LEN8 : STX_LEN6;
  assign loop_arm = misc_r[STX_MISC_LOOP_BIT] & misc_r[STX_MISC_POLL_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Receiver.
  logic [15:0] rx_sh_r, rx_win;
  logic        rx_search_r, rx_en_prev_r, rx_avail_r, rx_match, rx_done;
  logic [4:0]  rx_cnt_r;
  logic [7:0]  rx_data_r;
  logic        ev_r;

  assign rx_win   = {rxd_s, rx_sh_r[15:1]};
  assign rx_match = (mode_r[STX_MODE_PAT16] & char8) ? (rx_win == {pat2_r, pat1_r}) :
                    char8 ? (rx_win[15:8] == pat1_r) : (rx_win[15:10] == pat1_r[5:0]);
  assign rx_done  = rx_tick & rx_ctl_r[STX_RX_EN_BIT] & ~rx_search_r & (rx_cnt_r + 5'h01 == ch_len);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_sh_r <= 16'hFFFF;
    end else if (rx_tick) begin
      rx_sh_r <= rx_win;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_search_r  <= 1'b1;
      rx_en_prev_r <= 1'b0;
    end else begin
      rx_en_prev_r <= rx_ctl_r[STX_RX_EN_BIT];
      if (search_cmd || (rx_ctl_r[STX_RX_EN_BIT] && !rx_en_prev_r)) begin
        rx_search_r <= 1'b1;
      end else if (ext_on && mode_r[STX_MODE_SDLC] && align_rise) begin
        rx_search_r <= 1'b1;
      end else if (ext_on && align_fall) begin
        rx_search_r <= 1'b0;
      end else if (!ext_on && rx_tick && rx_search_r && rx_match) begin
        rx_search_r <= 1'b0;
      end
    end
  end

  // In external alignment no internal match ever resynchronises the
  // receiver: characters flow until the host commands a new search or, in SDLC, the pin rises.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_cnt_r <= 5'h00;
    end else if (rx_search_r) begin
      rx_cnt_r <= 5'h00;
    end else if (rx_tick && rx_ctl_r[STX_RX_EN_BIT]) begin
      rx_cnt_r <= rx_done ? 5'h00 : rx_cnt_r + 5'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_data_r <= 8'h00;
    end else if (rx_done) begin
      rx_data_r <= char8 ? rx_win[15:8] : {2'b00, rx_win[15:10]};
    end
  end

  // A character landing in the cycle the host reads keeps the flag set.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_avail_r <= 1'b0;
    end else if (rx_done) begin
      rx_avail_r <= 1'b1;
    end else if (rd_fire && s_axi_araddr == STX_RX_DATA_OFS) begin
      rx_avail_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev_r <= 1'b0;
    end else if (ext_on && align_ie_r && (align_fall || align_rise)) begin
      ev_r <= 1'b1;
    end else if (wr_b0 && aw_addr_r == STX_STATUS_OFS && w_data_r[STX_ST_EVENT_BIT]) begin
      ev_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter-to-receiver alignment: once the receiver leaves search, wait
  // one receive character time before letting the transmitter start.
  logic       lp_wait_r, tx_go_r, search_prev_r;
  logic [4:0] lp_cnt_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lp_wait_r     <= 1'b0;
      tx_go_r       <= 1'b0;
      lp_cnt_r      <= 5'h00;
      search_prev_r <= 1'b1;
    end else begin
      search_prev_r <= rx_search_r;
      if (!loop_arm) begin
        lp_wait_r <= 1'b0;
        tx_go_r   <= 1'b0;
      end else if (!tx_go_r && search_prev_r && !rx_search_r) begin
        lp_wait_r <= 1'b1;
        lp_cnt_r  <= 5'h00;
      end else if (lp_wait_r && rx_tick) begin
        lp_cnt_r <= lp_cnt_r + 5'h01;
        if (lp_cnt_r + 5'h01 == ch_len) begin
          lp_wait_r <= 1'b0;
          tx_go_r   <= 1'b1;
        end
      end
    end
  end

  assign tx_on = tx_ctl_r[STX_TX_EN_BIT] & (~loop_arm | tx_go_r);

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter.
  stx_tx_state_t tx_state_r, nx_state;
  logic [15:0]   tx_sh_r, pat_sh_r, nx_char, crc_q;
  logic [4:0]    tx_cnt_r, nx_len;
  logic          tx_crc_on_r, nx_crc_on, pat_idx_r, nx_pat_idx, nx_take;
  logic          crc_dirty_r, chk_abort_r, bnd, single_pat, crc_step, crc_init;

  // External alignment forces a single pattern, which is what transparent
  // transmission relies on: the first pattern character goes out first.
  assign single_pat = ~mode_r[STX_MODE_PAT16] | ext_on | ~char8;
  assign bnd        = (tx_cnt_r == 5'h00);

  always_comb begin
    nx_state   = STX_TX_IDLE;
    nx_char    = 16'h0000;
    nx_len     = 5'h00;
    nx_crc_on  = 1'b0;
    nx_pat_idx = 1'b0;
    nx_take    = 1'b0;
    if (!tx_on) begin
      nx_state = STX_TX_IDLE;
    end else if (tx_state_r == STX_TX_PAT && !single_pat && !pat_idx_r) begin
      nx_state   = STX_TX_PAT;
      nx_char    = {8'h00, pat2_r};
      nx_len     = ch_len;
      nx_pat_idx = 1'b1;
    end else if (tx_state_r != STX_TX_IDLE && tx_state_r != STX_TX_CHK && tx_buf_full_r) begin
      nx_state  = STX_TX_DATA;
      nx_char   = {8'h00, tx_buf_r};
      nx_len    = ch_len;
      nx_crc_on = tx_ctl_r[STX_TX_CRC_BIT];
      nx_take   = 1'b1;
    end else if (tx_state_r == STX_TX_DATA && crc_dirty_r) begin
      nx_state = STX_TX_CHK;
      nx_char  = {<<{crc_q}};
      nx_len   = STX_LEN16;
    end else begin
      nx_state = STX_TX_PAT;
      nx_char  = {8'h00, pat1_r};
      nx_len   = ch_len;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_state_r  <= STX_TX_IDLE;
      tx_sh_r     <= 16'h0000;
      pat_sh_r    <= 16'h0000;
      tx_cnt_r    <= 5'h00;
      tx_crc_on_r <= 1'b0;
      pat_idx_r   <= 1'b0;
      chk_abort_r <= 1'b0;
      txd         <= 1'b1;
    end else if (tx_tick) begin
      if (bnd) begin
        tx_state_r  <= nx_state;
        tx_sh_r     <= nx_char >> 1;
        pat_sh_r    <= {pat2_r, pat1_r} >> 1;
        tx_cnt_r    <= (nx_state == STX_TX_IDLE) ? 5'h00 : nx_len - 5'h01;
        tx_crc_on_r <= nx_crc_on;
        pat_idx_r   <= nx_pat_idx;
        chk_abort_r <= 1'b0;
        txd         <= (nx_state == STX_TX_IDLE) ? ~tx_ctl_r[STX_TX_BREAK_BIT] : nx_char[0];
      end else begin
        tx_sh_r  <= tx_sh_r >> 1;
        pat_sh_r <= pat_sh_r >> 1;
        tx_cnt_r <= tx_cnt_r - 5'h01;
        if (tx_state_r == STX_TX_CHK && (chk_abort_r || !tx_on)) begin
          chk_abort_r <= 1'b1;
          txd         <= pat_sh_r[0];
        end else begin
          txd <= tx_sh_r[0];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      crc_dirty_r <= 1'b0;
    end else if (tx_tick && bnd) begin
      if (nx_take && nx_crc_on) begin
        crc_dirty_r <= 1'b1;
      end else if (nx_state == STX_TX_CHK || nx_state == STX_TX_IDLE) begin
        crc_dirty_r <= 1'b0;
      end
    end
  end

  // Buffer refill by the host in the same cycle as a move keeps it full.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_buf_r      <= 8'h00;
      tx_buf_full_r <= 1'b0;
    end else if (wr_b0 && aw_addr_r == STX_TX_BUF_OFS) begin
      tx_buf_r      <= w_data_r[7:0];
      tx_buf_full_r <= 1'b1;
    end else if (tx_tick && bnd && nx_take) begin
      tx_buf_full_r <= 1'b0;
    end
  end

  assign crc_step = tx_tick & (bnd ? nx_crc_on : (tx_crc_on_r & tx_state_r == STX_TX_DATA));
  assign crc_init = tx_tick & bnd & (nx_state == STX_TX_PAT) & ~nx_pat_idx;

  stx_crc16 u_crc (
    .aclk    (aclk),
    .aresetn (aresetn),
    .init    (crc_init),
    .step    (crc_step),
    .din     (bnd ? nx_char[0] : tx_sh_r[0]),
    .crc     (crc_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read side.
  always_comb begin
    rd_ok  = 1'b1;
    rd_val = 8'h00;
    case (s_axi_araddr)
      STX_RX_CTRL_OFS:  rd_val = rx_ctl_r;
      STX_MODE_OFS:     rd_val = mode_r;
      STX_TX_CTRL_OFS:  rd_val = tx_ctl_r;
      STX_PAT1_OFS:     rd_val = pat1_r;
      STX_PAT2_OFS:     rd_val = pat2_r;
      STX_MISC_OFS:     rd_val = misc_r;
      STX_CLK_MODE_OFS: rd_val = clk_mode_r;
      STX_STATUS_OFS: begin
        rd_val[STX_ST_AVAIL_BIT]  = rx_avail_r;
        rd_val[STX_ST_TXMT_BIT]   = ~tx_buf_full_r;
        rd_val[STX_ST_SEARCH_BIT] = ext_on ? align_s : rx_search_r;
        rd_val[STX_ST_EVENT_BIT]  = ev_r;
      end
      STX_TX_BUF_OFS:   rd_val = tx_buf_r;
      STX_RX_DATA_OFS:  rd_val = rx_data_r;
      STX_EXT_CTRL_OFS: rd_val[STX_EXT_IE_BIT] = align_ie_r;
      default:          rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= STX_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h000000, rd_val};
      s_axi_rresp  <= rd_ok ? STX_RESP_OKAY : STX_RESP_SLV;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : stx_framer

// >>> verif/stx_framer_props.sv
module stx_framer_props
  import stx_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        tx_bit_clk,
  input wire logic        txd
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
    && $stable(s_axi_rresp)) else $error("read response dropped early");
  r_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  b_latency_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  w_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  b_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  tx_edge_a: assert property ($changed(txd) |-> !$past(tx_bit_clk))
    else $error("serial output moved without a bit clock fall");
  // A stopped bit clock must freeze the line, whatever the framer state.
  tx_still_a: assert property (tx_bit_clk [*6] |=> $stable(txd))
    else $error("serial output moved with bit clock stopped");
endmodule : stx_framer_props

bind stx_framer stx_framer_props u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_bit_clk, .txd);

// >>> verif/stx_peer.sv
module stx_peer (
  output logic      tx_bit_clk,
  output logic      rx_bit_clk,
  output logic      rxd,
  output logic      align_n,
  input  wire logic txd
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [63:0] cap;
  int          ncap;

  // Bit clocks stand high between frames; the offset keeps edges off the system clock.
  initial begin
    tx_bit_clk = 1'b1;
    rx_bit_clk = 1'b1;
    rxd        = 1'b1;
    align_n    = 1'b1;
    cap        = '0;
    ncap       = 0;
  end

  task automatic clr();
    cap  = '0;
    ncap = 0;
  endtask : clr

  // The line is sampled just before the next fall, well after it settled.
  task automatic tx_run(input int n);
    #7;
    for (int i = 0; i < n; i++) begin
      tx_bit_clk = 1'b0;
      #160;
      tx_bit_clk = 1'b1;
      #159;
      cap[ncap] = txd;
      ncap++;
      #1;
    end
  endtask : tx_run

  task automatic rx_byte(input logic [7:0] v);
    #7;
    for (int i = 0; i < 8; i++) begin
      rxd        = v[i];
      rx_bit_clk = 1'b0;
      #160;
      rx_bit_clk = 1'b1;
      #160;
    end
    rxd = ~v[7];
  endtask : rx_byte

  task automatic align(input logic v);
    #7 align_n = v;
  endtask : align
endmodule : stx_peer

// >>> verif/stx_framer_test.sv
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %0t got %h want %h", $time, (a), (e)); end end

module stx_framer_test
  import stx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e; logic [1:0] r;} stx_row_t;
  localparam stx_row_t ROWS [10] = '{
    '{8'h04, 8'h0F, 8'h0F, 2'h0}, '{8'h0C, 8'hA5, 8'hA5, 2'h0}, '{8'h10, 8'h3C, 8'h3C, 2'h0},
    '{8'h14, 8'h12, 8'h12, 2'h0}, '{8'h18, 8'h80, 8'h80, 2'h0}, '{8'h18, 8'h00, 8'h00, 2'h0},
    '{8'h28, 8'h01, 8'h01, 2'h0}, '{8'h08, 8'h11, 8'h11, 2'h0}, '{8'h00, 8'h11, 8'h01, 2'h0},
    '{8'h2C, 8'h5A, 8'h00, 2'h2}};

  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, q;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        tx_bit_clk, rx_bit_clk, rxd, align_n, txd;
  int          n_errors, checks, cyc;

  stx_framer u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .tx_bit_clk(tx_bit_clk), .rx_bit_clk(rx_bit_clk), .rxd(rxd),
    .align_n(align_n), .txd(txd));
  stx_peer u_peer (.tx_bit_clk(tx_bit_clk), .rx_bit_clk(rx_bit_clk), .rxd(rxd),
    .align_n(align_n), .txd(txd));

  always #20 aclk = ~aclk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (n_errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      stop_test();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = 2'h0);
    bit ta = 0, tw = 0, done = 0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1 && !ta) begin
        ta = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1 && !tw) begin
        tw = 1;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid === 1'b1) begin
        done = 1;
        s_axi_bready <= 1'b0;
        `CHK(s_axi_bresp, r)
      end
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [1:0] r = 2'h0);
    bit done = 0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        done = 1;
        q = s_axi_rdata;
        s_axi_rready <= 1'b0;
        `CHK(s_axi_rresp, r)
      end
    end
  endtask : rd

  // Pattern, data, then the high check byte MSB first; the opening pattern left out of the check.
  function automatic logic [23:0] chk_exp(input logic [7:0] p, input logic [7:0] d);
    logic [15:0] c;
    logic [7:0]  h;
    c = STX_CRC_PRESET;
    for (int i = 0; i < 8; i++) c = {c[14:0], 1'b0} ^ ((d[i] ^ c[15]) ? STX_CRC_POLY : 16'h0000);
    for (int j = 0; j < 8; j++) h[j] = c[15-j];
    return {h, d, p};
  endfunction : chk_exp

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (ROWS[i]) begin
      wr(ROWS[i].a, ROWS[i].d, ROWS[i].r);
      rd(ROWS[i].a, ROWS[i].r);
      `CHK(q, {24'h000000, ROWS[i].e})
    end
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(STX_PAT1_OFS);
    `CHK(q[7:0], STX_REG_RST)
    rd(STX_TX_CTRL_OFS);
    `CHK(q[7:0], STX_REG_RST)
    u_peer.tx_run(8);
    `CHK(u_peer.cap[7:0], 8'hFF)
    wr(STX_TX_CTRL_OFS, 8'h10);
    u_peer.tx_run(2);
    u_peer.clr();
    u_peer.tx_run(8);
    `CHK(u_peer.cap[7:0], 8'h00)
    wr(STX_TX_CTRL_OFS, 8'h00);
    u_peer.tx_run(4);
    wr(STX_MODE_OFS, 8'h05);
    wr(STX_PAT1_OFS, 8'h5A);
    wr(STX_TX_CTRL_OFS, 8'h08);
    u_peer.clr();
    u_peer.tx_run(2);
    wr(STX_TX_BUF_OFS, 8'hC3);
    u_peer.tx_run(8);
    wr(STX_TX_CTRL_OFS, 8'h00);
    u_peer.tx_run(14);
    `CHK(u_peer.cap[23:0], 24'hFFC35A)
    wr(STX_MODE_OFS, 8'h01);
    wr(STX_PAT1_OFS, 8'h7E);
    wr(STX_PAT2_OFS, 8'h96);
    wr(STX_TX_CTRL_OFS, 8'h09);
    u_peer.clr();
    u_peer.tx_run(2);
    wr(STX_TX_BUF_OFS, 8'h31);
    u_peer.tx_run(22);
    `CHK(u_peer.cap[23:0], chk_exp(8'h7E, 8'h31))
    wr(STX_TX_CTRL_OFS, 8'h00);
    u_peer.clr();
    u_peer.tx_run(16);
    `CHK(u_peer.cap[15:0], 16'hFF96)
    wr(STX_MODE_OFS, 8'h05);
    wr(STX_EXT_CTRL_OFS, 8'h01);
    wr(STX_RX_CTRL_OFS, 8'h11);
    rd(STX_STATUS_OFS);
    `CHK(q[STX_ST_SEARCH_BIT], 1'b1)
    u_peer.align(1'b0);
    repeat (6) @(posedge aclk);
    rd(STX_STATUS_OFS);
    `CHK(q[STX_ST_SEARCH_BIT], 1'b0)
    `CHK(q[STX_ST_EVENT_BIT], 1'b1)
    u_peer.rx_byte(8'h96);
    repeat (8) @(posedge aclk);
    rd(STX_STATUS_OFS);
    `CHK(q[STX_ST_AVAIL_BIT], 1'b1)
    rd(STX_RX_DATA_OFS);
    `CHK(q[7:0], 8'h96)
    u_peer.rx_byte(8'h4B);
    repeat (8) @(posedge aclk);
    rd(STX_RX_DATA_OFS);
    `CHK(q[7:0], 8'h4B)
    wr(STX_STATUS_OFS, 8'h40);
    u_peer.align(1'b1);
    repeat (6) @(posedge aclk);
    rd(STX_STATUS_OFS);
    `CHK(q[STX_ST_EVENT_BIT], 1'b1)
    wr(STX_RX_CTRL_OFS, 8'h11);
    u_peer.rx_byte(8'hA5);
    repeat (8) @(posedge aclk);
    rd(STX_STATUS_OFS);
    `CHK(q[STX_ST_AVAIL_BIT], 1'b0)
    wr(STX_MISC_OFS, 8'h02);
    wr(STX_TX_CTRL_OFS, 8'h08);
    wr(STX_MISC_OFS, 8'h12);
    wr(STX_RX_CTRL_OFS, 8'h11);
    u_peer.align(1'b0);
    u_peer.clr();
    u_peer.tx_run(8);
    u_peer.rx_byte(8'h00);
    u_peer.tx_run(8);
    `CHK(u_peer.cap[15:0], 16'h7EFF)
    stop_test();
  end
endmodule : stx_framer_test
